// ==== pkg/rpt_consts.svh ====
// Timing, reset values and encodings for the RSSI PWM output timers
`ifndef RPT_CONSTS_SVH
`define RPT_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and modulation timing
// ----------------------------------------------------------------
`define RPT_CLK_PERIOD_NS    50
`define RPT_PWM_PERIOD_NS    64000
`define RPT_PWM_PERIOD_CYC   (`RPT_PWM_PERIOD_NS / `RPT_CLK_PERIOD_NS)
`define RPT_PWM_STEPS        445
`define RPT_STEP_NS          144
`define RPT_UNIT_MS          100
`define RPT_UNIT_CYC         (`RPT_UNIT_MS * 1000000 / `RPT_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Signal strength mapping, percent times 100 and PWM steps
// ----------------------------------------------------------------
`define RPT_RSSI_BASE_PCT100  2400
`define RPT_RSSI_SLOPE_PCT100 170
`define RPT_PCT100_FULL       10000
`define RPT_RSSI_FLOOR_STEPS  9'h06b
`define RPT_BELOW_SENS_STEPS  9'h035

// ----------------------------------------------------------------
// Reset values and special settings
// ----------------------------------------------------------------
`define RPT_HOLD_RESET       8'h28
`define RPT_TIMEOUT_RESET    8'hff
`define RPT_HOLD_FOREVER     8'hff
`define RPT_TIMER_OFF        8'h00

`endif

// ==== pkg/rpt_pkg.sv ====
// Types shared by the RSSI PWM output timers
package rpt_pkg;

  typedef enum logic [1:0] {
    RPT_FN_DISABLED = 2'h0,
    RPT_FN_RSSI     = 2'h1,
    RPT_FN_PASS     = 2'h2,
    RPT_FN_RSVD     = 2'h3
  } rpt_func_t;

  typedef enum logic [1:0] {
    RPT_CFG_HOLD    = 2'h0,
    RPT_CFG_TIMEOUT = 2'h1,
    RPT_CFG_SEL_A   = 2'h2,
    RPT_CFG_SEL_B   = 2'h3
  } rpt_cfg_t;

endpackage : rpt_pkg

// ==== verilog/rpt_pwm_timers.sv ====
// RSSI display and line-passing PWM outputs with hold and timeout timers
//
// Behaviour
// - Each output repeats a fixed 64 us period while active.
// - Each period holds 445 steps of 2 or 3 cycles, about 144 ns on average.
// - Signal strength is shown at 24 to 100 percent duty; zero duty means inactive.
// - A duty between one and 24 percent marks a packet at or below sensitivity.
// - 10, 20 and 30 dB above sensitivity give 41, 58 and 75 percent duty.
// - A hold time of 0x01 to 0xfe shows the last strength that many 100 ms units, then low.
// - The strength output stays low from power-up until the first radio packet.
// - A hold time of 0xff never times out and always shows the last packet.
// - The hold time is eight bits in 100 ms units and resets to 0x28.
// - One eight-bit timeout in 100 ms units, reset 0xff, covers both outputs.
// - A passed-through non-zero duty starts the timeout; expiry forces zero duty.
// - Each valid I/O sample packet restarts the timeout from its full setting.
// - Output A select: 0 disabled, 1 strength, 2 passed-through; resets to 1.
// - Output B select uses the same coding and resets to disabled.
`timescale 1ns/1ps
`include "rpt_consts.svh"

module rpt_pwm_timers #(
  parameter int unsigned UNIT_CYCLES = `RPT_UNIT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       cfg_wr_en,
  input  wire logic [1:0] cfg_index,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  input  wire logic       rx_pkt_stb,
  input  wire logic       rx_below_sens,
  input  wire logic [7:0] rx_margin_db,
  input  wire logic       io_pkt_stb,
  input  wire logic [8:0] io_duty_a,
  input  wire logic [8:0] io_duty_b,
  output logic            modulated_output_a,
  output logic            modulated_output_b,
  output logic            rssi_active
);

  localparam int unsigned UW = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
  localparam logic [10:0] PERIOD_CYC = 11'(`RPT_PWM_PERIOD_CYC);
  localparam logic [10:0] STEP_INC   = 11'(`RPT_PWM_STEPS);
  localparam logic [8:0]  LAST_STEP  = 9'(`RPT_PWM_STEPS - 1);
  localparam logic [8:0]  FULL_STEPS = 9'(`RPT_PWM_STEPS);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Linear fit through the three calibration points, rounded up
  function automatic logic [8:0] rpt_rssi_steps(input logic [7:0] db);
    logic [31:0] pct;
    logic [31:0] prod;
    pct  = `RPT_RSSI_BASE_PCT100 + `RPT_RSSI_SLOPE_PCT100 * 32'(db);
    prod = (pct * `RPT_PWM_STEPS + `RPT_PCT100_FULL - 1) / `RPT_PCT100_FULL;
    if (pct >= `RPT_PCT100_FULL) begin
      return FULL_STEPS;
    end
    return prod[8:0];
  endfunction : rpt_rssi_steps
  function automatic logic [8:0] rpt_clamp(input logic [8:0] d);
    return (d > FULL_STEPS) ? FULL_STEPS : d;
  endfunction : rpt_clamp
  function automatic logic [8:0] rpt_target(input logic [1:0] sel, input logic valid,
                                            input logic [8:0] rssi, input logic [8:0] pass);
    case (sel)
      rpt_pkg::RPT_FN_RSSI: return valid ? rssi : 9'h000;
      rpt_pkg::RPT_FN_PASS: return pass;
      default:              return 9'h000;
    endcase
  endfunction : rpt_target

  // ----------------------------------------------------------------
  // Configuration settings
  // ----------------------------------------------------------------
  logic [7:0] hold_reg;
  logic [7:0] timeout_reg;
  logic [1:0] sel_a_reg;
  logic [1:0] sel_b_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg    <= `RPT_HOLD_RESET;
      timeout_reg <= `RPT_TIMEOUT_RESET;
      sel_a_reg   <= rpt_pkg::RPT_FN_RSSI;
      sel_b_reg   <= rpt_pkg::RPT_FN_DISABLED;
    end else if (cfg_wr_en) begin
      case (cfg_index)
        rpt_pkg::RPT_CFG_HOLD:    hold_reg    <= cfg_wdata;
        rpt_pkg::RPT_CFG_TIMEOUT: timeout_reg <= cfg_wdata;
        rpt_pkg::RPT_CFG_SEL_A:   sel_a_reg   <= cfg_wdata[1:0];
        rpt_pkg::RPT_CFG_SEL_B:   sel_b_reg   <= cfg_wdata[1:0];
        default:                  hold_reg    <= hold_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 8'h00;
    end else begin
      case (cfg_index)
        rpt_pkg::RPT_CFG_HOLD:    cfg_rdata <= hold_reg;
        rpt_pkg::RPT_CFG_TIMEOUT: cfg_rdata <= timeout_reg;
        rpt_pkg::RPT_CFG_SEL_A:   cfg_rdata <= {6'h00, sel_a_reg};
        rpt_pkg::RPT_CFG_SEL_B:   cfg_rdata <= {6'h00, sel_b_reg};
        default:                  cfg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Step generator
  // ----------------------------------------------------------------
  // 445 steps cannot divide 1280 cycles evenly; a fractional accumulator
  // spreads them so the period stays exact at the cost of 2-3 cycle steps
  logic [10:0] acc_reg;
  logic [10:0] acc_sum;
  logic [8:0]  step_reg;
  logic        step_tick;
  logic        period_end;

  assign acc_sum    = acc_reg + STEP_INC;
  assign step_tick  = (acc_sum >= PERIOD_CYC);
  assign period_end = step_tick && (step_reg == LAST_STEP);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg  <= 11'h000;
      step_reg <= 9'h000;
    end else begin
      acc_reg <= step_tick ? (acc_sum - PERIOD_CYC) : acc_sum;
      if (step_tick) begin
        step_reg <= period_end ? 9'h000 : step_reg + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // 100 ms unit prescaler, shared by both timers
  // ----------------------------------------------------------------
  // Shared tick: a restart may see its first unit short by up to 100 ms
  logic [UW-1:0] unit_cnt_reg;
  logic          unit_tick;

  assign unit_tick = (unit_cnt_reg == UW'(UNIT_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_cnt_reg <= '0;
    end else begin
      unit_cnt_reg <= unit_tick ? '0 : unit_cnt_reg + UW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Signal strength capture and hold timer
  // ----------------------------------------------------------------
  logic [8:0] rssi_steps_reg;
  logic [7:0] hold_cnt_reg;
  logic       rssi_seen_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rssi_steps_reg <= 9'h000;
      rssi_seen_reg  <= 1'b0;
    end else if (rx_pkt_stb) begin
      rssi_seen_reg  <= 1'b1;
      rssi_steps_reg <= rx_below_sens ? `RPT_BELOW_SENS_STEPS
                                      : rpt_rssi_steps(rx_margin_db);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rssi_active  <= 1'b0;
      hold_cnt_reg <= 8'h00;
    end else if (rx_pkt_stb) begin
      rssi_active  <= (hold_reg != `RPT_TIMER_OFF);
      hold_cnt_reg <= hold_reg;
    end else if (unit_tick && rssi_active && hold_reg != `RPT_HOLD_FOREVER) begin
      hold_cnt_reg <= hold_cnt_reg - 8'h01;
      if (hold_cnt_reg <= 8'h01) begin
        rssi_active <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line-passing duties and output timeout
  // ----------------------------------------------------------------
  logic [8:0] pass_reg [2];
  logic [7:0] to_cnt_reg;
  logic       to_expire;

  assign to_expire = unit_tick && (timeout_reg != `RPT_TIMER_OFF) && (to_cnt_reg == 8'h01);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pass_reg[0] <= 9'h000;
      pass_reg[1] <= 9'h000;
      to_cnt_reg  <= 8'h00;
    end else if (io_pkt_stb) begin
      pass_reg[0] <= rpt_clamp(io_duty_a);
      pass_reg[1] <= rpt_clamp(io_duty_b);
      to_cnt_reg  <= timeout_reg;
    end else if (unit_tick && timeout_reg != `RPT_TIMER_OFF && to_cnt_reg != 8'h00) begin
      to_cnt_reg <= to_cnt_reg - 8'h01;
      if (to_expire) begin
        pass_reg[0] <= 9'h000;
        pass_reg[1] <= 9'h000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output generation
  // ----------------------------------------------------------------
  logic [1:0] sel_w [2];
  logic [8:0] duty_reg [2];
  logic       out_reg [2];

  assign sel_w[0]           = sel_a_reg;
  assign sel_w[1]           = sel_b_reg;
  assign modulated_output_a = out_reg[0];
  assign modulated_output_b = out_reg[1];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  for (genvar i = 0; i < 2; i++) begin : g_out
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        duty_reg[i] <= 9'h000;
        out_reg[i]  <= 1'b0;
      end else begin
        if (period_end) begin
          duty_reg[i] <= rpt_target(sel_w[i], rssi_active, rssi_steps_reg,
                                    pass_reg[i]);
        end
        out_reg[i] <= (step_reg < duty_reg[i]);
      end
    end
    a_pwm_shape: assert property (
        ##1 out_reg[i] == ($past(step_reg) < $past(duty_reg[i])))
      else $error("output level does not follow step position");
    a_duty_boundary: assert property ($changed(duty_reg[i]) |-> $past(period_end))
      else $error("duty changed away from a period boundary");
    a_duty_range: assert property (duty_reg[i] <= FULL_STEPS)
      else $error("duty exceeds full period");
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [10:0] cyc_reg;
  logic        wrapped_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg     <= 11'h000;
      wrapped_reg <= 1'b0;
    end else begin
      cyc_reg     <= period_end ? 11'h000 : cyc_reg + 11'h001;
      wrapped_reg <= wrapped_reg | period_end;
    end
  end
  a_period_len: assert property (period_end && wrapped_reg |->
      cyc_reg == PERIOD_CYC - 11'h001)
    else $error("period is not 1280 cycles");
  a_step_bound: assert property (step_reg <= LAST_STEP)
    else $error("step counter beyond last step");
  a_rssi_floor: assert property (rx_pkt_stb && !rx_below_sens |=>
      rssi_steps_reg >= `RPT_RSSI_FLOOR_STEPS)
    else $error("strength duty below 24 percent");
  a_below_sens: assert property (rx_pkt_stb && rx_below_sens |=>
      rssi_steps_reg != 9'h000 && rssi_steps_reg < `RPT_RSSI_FLOOR_STEPS)
    else $error("sensitivity marker outside 1 to 24 percent");
  a_cal_point: assert property (rx_pkt_stb && !rx_below_sens && rx_margin_db == 8'h14 |=>
      rssi_steps_reg == 9'h103)
    else $error("20 dB does not map to 58 percent");
  a_hold_expire: assert property (unit_tick && rssi_active && !rx_pkt_stb
      && hold_cnt_reg == 8'h01 && hold_reg != `RPT_HOLD_FOREVER |=> !rssi_active)
    else $error("strength display outlived its hold time");
  a_powerup_low: assert property (!rssi_seen_reg |-> !rssi_active)
    else $error("strength shown before any packet");
  a_hold_forever: assert property (rssi_active && hold_reg == `RPT_HOLD_FOREVER |=>
      rssi_active)
    else $error("permanent hold timed out");
  a_timeout_zero: assert property (to_expire && !io_pkt_stb |=>
      pass_reg[0] == 9'h000 && pass_reg[1] == 9'h000)
    else $error("timeout did not clear passed duties");
  a_io_restart: assert property (io_pkt_stb |=> to_cnt_reg == $past(timeout_reg))
    else $error("I/O packet did not restart timeout");
  c_rssi_shown: cover property (period_end && rssi_active ##1 duty_reg[0] != 9'h000);
  c_hold_expired: cover property (rssi_active ##1 !rssi_active);
  c_timeout_hit: cover property (to_expire && !io_pkt_stb);
  c_pass_out: cover property (sel_b_reg == rpt_pkg::RPT_FN_PASS && out_reg[1]);
endmodule : rpt_pwm_timers

// ==== verif/rpt_meter.sv ====
// Meter model that measures pulse width, period and idle time of one PWM line
`timescale 1ns/1ps

module rpt_meter (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        pwm_in,
  output logic      [15:0] hi_len,
  output logic      [15:0] per_len,
  output logic      [15:0] low_run
);
  logic        prev_reg;
  logic [15:0] run_reg;
  logic [15:0] since_reg;

  // Passive input: only samples, never loads the line
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg  <= 1'b0;
      run_reg   <= 16'h0000;
      since_reg <= 16'h0000;
      hi_len    <= 16'h0000;
      per_len   <= 16'h0000;
      low_run   <= 16'h0000;
    end else begin
      prev_reg <= pwm_in;
      if (pwm_in && !prev_reg) begin
        run_reg   <= 16'h0001;
        per_len   <= since_reg;
        since_reg <= 16'h0001;
      end else begin
        since_reg <= since_reg + 16'h0001;
        if (pwm_in) begin
          run_reg <= run_reg + 16'h0001;
        end
      end
      if (!pwm_in && prev_reg) begin
        hi_len <= run_reg;
      end
      // Saturate so a long idle never wraps back to a small value
      if (pwm_in) begin
        low_run <= 16'h0000;
      end else if (low_run != 16'hffff) begin
        low_run <= low_run + 16'h0001;
      end
    end
  end
endmodule : rpt_meter

// ==== verif/test_rpt_pwm_timers.sv ====
// Self-checking bench for the RSSI PWM output timers
`timescale 1ns/1ps

module test_rpt_pwm_timers;
  localparam int UNIT = 200;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cfg_wr_en = 1'b0;
  logic [1:0]  cfg_index = 2'h0;
  logic [7:0]  cfg_wdata = 8'h00;
  logic [7:0]  cfg_rdata;
  logic        rx_pkt_stb = 1'b0;
  logic        rx_below_sens = 1'b0;
  logic [7:0]  rx_margin_db = 8'h00;
  logic        io_pkt_stb = 1'b0;
  logic [8:0]  io_duty_a = 9'h000;
  logic [8:0]  io_duty_b = 9'h000;
  logic        out_a;
  logic        out_b;
  logic        rssi_active;
  logic [15:0] hi_a, per_a, low_a, hi_b, per_b, low_b;
  int          err_count = 0;
  int          tests_run = 0;

  rpt_pwm_timers #(.UNIT_CYCLES(UNIT)) rpt_pwm_timers_i (
    .core_clk(core_clk), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en), .cfg_index(cfg_index),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .rx_pkt_stb(rx_pkt_stb),
    .rx_below_sens(rx_below_sens), .rx_margin_db(rx_margin_db), .io_pkt_stb(io_pkt_stb),
    .io_duty_a(io_duty_a), .io_duty_b(io_duty_b), .modulated_output_a(out_a),
    .modulated_output_b(out_b), .rssi_active(rssi_active));
  rpt_meter meter_a_i (.core_clk(core_clk), .rst_n(rst_n), .pwm_in(out_a),
    .hi_len(hi_a), .per_len(per_a), .low_run(low_a));
  rpt_meter meter_b_i (.core_clk(core_clk), .rst_n(rst_n), .pwm_in(out_b),
    .hi_len(hi_b), .per_len(per_b), .low_run(low_b));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Access tasks and compares
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : cyc

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_range(input logic [15:0] got, input int lo, input int hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_range

  task automatic cfg_write(input logic [1:0] idx, input logic [7:0] val);
    cyc(1);
    cfg_wr_en = 1'b1;
    cfg_index = idx;
    cfg_wdata = val;
    cyc(1);
    cfg_wr_en = 1'b0;
  endtask : cfg_write

  task automatic cfg_check(input logic [1:0] idx, input logic [7:0] exp);
    cyc(1);
    cfg_index = idx;
    cyc(2);
    check_val({8'h00, cfg_rdata}, {8'h00, exp});
  endtask : cfg_check

  task automatic radio_pkt(input logic below, input logic [7:0] db);
    cyc(1);
    rx_pkt_stb = 1'b1;
    rx_below_sens = below;
    rx_margin_db = db;
    cyc(1);
    rx_pkt_stb = 1'b0;
  endtask : radio_pkt

  task automatic io_pkt(input logic [8:0] da, input logic [8:0] db);
    cyc(1);
    io_pkt_stb = 1'b1;
    io_duty_a = da;
    io_duty_b = db;
    cyc(1);
    io_pkt_stb = 1'b0;
  endtask : io_pkt

  // Pulse of n steps spans n*1280/445 cycles, rounded either way
  task automatic check_steps(input logic [15:0] got, input int n);
    check_range(got, (n * 1280) / 445 - 1, (n * 1280) / 445 + 2);
  endtask : check_steps

  task automatic conclude;
    $display("Counts: %0d compares, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #3000000;
    err_count++;
    conclude();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    int db_tab[3];
    int st_tab[3];
    db_tab = '{10, 20, 30};
    st_tab = '{183, 259, 334};
    repeat (4) @(posedge core_clk);
    #5 rst_n = 1'b1;
    cfg_check(2'h0, 8'h28);
    cfg_check(2'h1, 8'hff);
    cfg_check(2'h2, 8'h01);
    cfg_check(2'h3, 8'h00);
    cyc(1500);
    check_range(low_a, 1280, 65535);
    check_val({15'h0, rssi_active}, 16'h0000);
    $display("Test reset values done");

    cfg_write(2'h0, 8'hff);
    for (int i = 0; i < 3; i++) begin
      radio_pkt(1'b0, db_tab[i][7:0]);
      cyc(3000);
      check_steps(hi_a, st_tab[i]);
      check_val(per_a, 16'd1280);
    end
    cyc(5000);
    check_val({15'h0, rssi_active}, 16'h0001);
    radio_pkt(1'b1, 8'h00);
    cyc(3000);
    check_range(hi_a, 13, 307);
    check_val(per_a, 16'd1280);
    $display("Test strength mapping done");

    cfg_write(2'h0, 8'h02);
    radio_pkt(1'b0, 8'd20);
    cyc(100);
    check_val({15'h0, rssi_active}, 16'h0001);
    cyc(400);
    check_val({15'h0, rssi_active}, 16'h0000);
    cyc(2600);
    check_range(low_a, 1280, 65535);
    $display("Test hold time done");

    cfg_write(2'h3, 8'h02);
    cfg_write(2'h1, 8'h03);
    for (int i = 0; i < 15; i++) begin
      io_pkt(9'd100, 9'd100);
      cyc(200);
    end
    check_steps(hi_b, 100);
    check_range(low_b, 0, 1279);
    cyc(2500);
    check_range(low_b, 1280, 65535);
    cfg_write(2'h2, 8'h00);
    radio_pkt(1'b0, 8'd30);
    cyc(1500);
    check_range(low_a, 1280, 65535);
    $display("Test pass-through and timeout done");

    cfg_write(2'h0, 8'h00);
    cfg_write(2'h1, 8'h00);
    cfg_write(2'h2, 8'h02);
    radio_pkt(1'b0, 8'd30);
    cyc(2);
    check_val({15'h0, rssi_active}, 16'h0000);
    io_pkt(9'd100, 9'd200);
    cyc(3000);
    check_steps(hi_a, 100);
    check_steps(hi_b, 200);
    check_range(low_b, 0, 1279);
    $display("Test zero settings done");
    conclude();
  end
endmodule : test_rpt_pwm_timers
